// ---- bench/srp_host_model.sv ----
// Host serial port model: sends framed characters, collects what it hears.
// Assumes the bench sets framing and bit length before traffic.
`timescale 1ns/1ns
`default_nettype none
module srp_host_model import srp_pkg::*; (
	input wire logic pclk,
	input wire logic txd,
	output logic rxd
);
	int unsigned bit_cyc = 20;
	logic data7 = 1'h0;
	srp_parity_type parity = PAR_NONE;
	logic flow = 1'h0;
	logic held = 1'h0;
	int perr = 0;
	int ferr = 0;
	logic [7:0] got_q[$];
	initial rxd = 1'h1;
	function automatic logic par_of(logic [7:0] c);
		return (data7 ? ^c[6:0] : ^c) ^ (parity == PAR_ODD);
	endfunction
	task automatic send_char(input logic [7:0] c);
		logic [10:0] fr;
		int d;
		while (held) @(posedge pclk);
		@(posedge pclk);
		d = data7 ? 7 : 8;
		fr = 11'h7ff;
		fr[0] = 1'h0;
		for (int i = 0; i < d; i++) fr[i+1] = c[i];
		if (parity != PAR_NONE) fr[d+1] = par_of(c);
		for (int i = 0; i < d + (parity != PAR_NONE) + 2; i++) begin
			rxd <= fr[i];
			repeat (bit_cyc) @(posedge pclk);
		end
	endtask
	initial begin
		logic [7:0] c;
		forever begin
			@(negedge txd);
			repeat (bit_cyc / 2) @(posedge pclk);
			c = 8'h00;
			for (int i = 0; i < (data7 ? 7 : 8); i++) begin
				repeat (bit_cyc) @(posedge pclk);
				c[i] = txd;
			end
			repeat (bit_cyc) @(posedge pclk);
			if (parity != PAR_NONE && txd !== par_of(c)) perr++;
			if (parity != PAR_NONE) repeat (bit_cyc) @(posedge pclk);
			if (txd !== 1'h1) ferr++;
			got_q.push_back(c);
			if (flow && c == CHR_XOFF) held = 1'h1;
			if (flow && c == CHR_XON) held = 1'h0;
		end
	end
endmodule
`default_nettype wire

// ---- bench/srp_serial_port_checker.sv ----
// Checker for the serial remote port: link timing and APB refusals.
// Assumes binding to srp_serial_port; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module srp_serial_port_checker import srp_pkg::*; #(
	parameter int unsigned CLK_HZ = CLK_HZ_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic txd,
	input wire logic cmd_ready,
	input wire logic abort_pulse
);
	localparam int unsigned MIN_BIT = CLK_HZ / BAUD_57600;
	logic txd_q;
	logic [19:0] run_q;
	logic wr_ctrl;
	logic rd_rx;
	assign wr_ctrl = psel && penable && pwrite && paddr == ADDR_CTRL;
	assign rd_rx = psel && penable && !pwrite && paddr == ADDR_RXDATA;
	// Run length of txd; a counter instead of a long repetition
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txd_q <= 1'h1;
			run_q <= 20'h0;
		end else begin
			txd_q <= txd;
			run_q <= (txd != txd_q) ? 20'h1 : run_q + 20'h1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_abort_one_cycle: assert property (abort_pulse |=> !abort_pulse)
		else $error("abort pulse lasted more than one cycle");
	a_idle_after_reset: assert property ($rose(presetn) |-> txd && !cmd_ready)
		else $error("link not idle after reset");
	a_low_full_bit: assert property ($rose(txd) |-> run_q >= MIN_BIT)
		else $error("low level on txd shorter than one bit");
	a_high_full_bit: assert property ($fell(txd) |-> run_q >= MIN_BIT)
		else $error("stop or idle on txd shorter than one bit");
	a_cmd_drop_read: assert property ($fell(cmd_ready) |->
		$past(rd_rx) || $past(rd_rx, 2) || $past(rd_rx, 3))
		else $error("command flag fell without a data read");
	a_seven_no_par: assert property (wr_ctrl && pwdata[4] && pwdata[6:5] == 2'h0 |-> pslverr)
		else $error("7 bits without parity accepted");
	a_baud_range: assert property (wr_ctrl && pwdata[3:0] > 4'h8 |-> pslverr)
		else $error("rate code above 8 accepted");
	a_parity_code: assert property (wr_ctrl && pwdata[6:5] == 2'h3 |-> pslverr)
		else $error("parity code 3 accepted");
	a_good_ctrl: assert property (wr_ctrl && pwdata[3:0] <= 4'h8 && pwdata[6:5] != 2'h3
		&& !(pwdata[4] && pwdata[6:5] == 2'h0) |-> !pslverr)
		else $error("legal setting refused");
endmodule
bind srp_serial_port srp_serial_port_checker #(.CLK_HZ(CLK_HZ)) u_chk (.pclk(pclk),
	.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .pslverr(pslverr), .txd(txd), .cmd_ready(cmd_ready),
	.abort_pulse(abort_pulse));
`default_nettype wire

// ---- bench/srp_serial_port_tb_top.sv ----
// Self-checking bench for the serial remote port with a host model on the link.
// Assumes a shortened clock rate: one bit at 57600 baud lasts 20 cycles.
`timescale 1ns/1ns
`default_nettype none
module srp_serial_port_tb_top import srp_pkg::*;;
	localparam int unsigned CLK = 1152000;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, rxd, txd, cmd_ready, abort_pulse, e;
	logic [31:0] r;
	logic [7:0] c;
	logic [7:0] rx3[3];
	logic [7:0] brk[2] = '{CHR_BREAK_C, CHR_BREAK_X};
	logic [7:0] bad_a[5] = '{8'h00, 8'h00, 8'h00, ADDR_RXDATA, 8'h10};
	logic [31:0] bad_d[5] = '{32'h0000_0010, 32'h0000_0009, 32'h0000_0060, 32'h0, 32'h0};
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0, aborts = 0;
	always #5 pclk = ~pclk;
	srp_serial_port #(.CLK_HZ(CLK)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .cmd_ready(cmd_ready),
		.abort_pulse(abort_pulse));
	srp_host_model host (.pclk(pclk), .txd(txd), .rxd(rxd));
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'h1;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	function automatic logic [31:0] ctrl(logic [3:0] b, logic d7, logic [1:0] p,
		logic [1:0] tm, logic f);
		return {22'h0, f, tm, p, d7, b};
	endfunction
	function automatic logic [7:0] term_chr(logic [1:0] tm, int i);
		return ((i == 0) ^ tm[1]) ? CHR_CR : CHR_LF;
	endfunction
	task automatic wait_got(input int n);
		for (int t = 0; t < 3000 && host.got_q.size() < n; t++) @(posedge pclk);
	endtask
	// Link must be idle: settings are not guarded mid-character
	task automatic setup(input logic d7, input logic [1:0] p, input logic [1:0] tm,
		input logic f);
		repeat (20) @(posedge pclk);
		apb(ADDR_CTRL, 1'h1, ctrl(4'h0, d7, p, tm, f));
		host.data7 = d7;
		host.parity = srp_parity_type'(p);
		host.flow = f;
		apb(ADDR_CTRL, 1'h0, 32'h0000_0000);
		check(r, ctrl(4'h0, d7, p, tm, f));
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (abort_pulse === 1'h1) aborts++;
		if (cyc == 60000) begin
			err_total++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(32'h6b32));
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		apb(ADDR_CTRL, 1'h0, 32'h0000_0000);
		check(r[3:0], 4'h3);
		check(r, 32'h0000_0003);
		for (int i = 0; i < 5; i++) begin
			apb(bad_a[i], 1'h1, bad_d[i]);
			check(e, 1'h1);
		end
		apb(ADDR_CTRL, 1'h0, 32'h0000_0000);
		check(r, 32'h0000_0003);
		for (int b = 8; b >= 0; b--) begin
			apb(ADDR_CTRL, 1'h1, ctrl(4'(b), 1'h0, 2'h0, 2'h0, 1'h0));
			check(e, 1'h0);
		end
		for (int tm = 0; tm < 4; tm++) begin
			c = 8'($urandom) & (tm[1] ? 8'h7f : 8'hff);
			setup(tm[1], (tm == 0) ? 2'h0 : (tm == 3) ? 2'h2 : 2'h1, 2'(tm), 1'h0);
			host.got_q.delete();
			apb(ADDR_TXDATA, 1'h1, {23'h0, 1'h1, c});
			wait_got(2 + tm[0]);
			check(host.got_q.size(), 2 + tm[0]);
			check(host.got_q[0], c);
			for (int i = 0; i <= tm[0]; i++) check(host.got_q[i+1], term_chr(2'(tm), i));
		end
		host.parity = PAR_EVEN;
		host.send_char(c);
		apb(ADDR_STATUS, 1'h0, 32'h0000_0000);
		check({r[16:15], r[6:0]}, 9'h100);
		setup(1'h0, 2'h0, 2'h0, 1'h0);
		c = 8'h41 + 8'($urandom % 26);
		rx3 = '{c, CHR_XOFF, CHR_CR};
		host.send_char(c);
		host.send_char(CHR_XOFF);
		repeat (30) @(posedge pclk);
		check(cmd_ready, 1'h0);
		host.send_char(CHR_CR);
		repeat (30) @(posedge pclk);
		check(cmd_ready, 1'h1);
		foreach (rx3[i]) begin
			apb(ADDR_RXDATA, 1'h0, 32'h0000_0000);
			check(r, {23'h0, 1'h1, rx3[i]});
		end
		repeat (3) @(posedge pclk);
		check(cmd_ready, 1'h0);
		foreach (brk[i]) begin
			for (int k = 0; k < 4; k++) apb(ADDR_TXDATA, 1'h1, 32'h0000_0055);
			host.send_char(8'h61);
			host.send_char(brk[i]);
			repeat (5) @(posedge pclk);
			check(aborts, i + 1);
			apb(ADDR_STATUS, 1'h0, 32'h0000_0000);
			check({r[18], r[12:8], r[6:0]}, 13'h1000);
			apb(ADDR_STATUS, 1'h1, 32'h0004_0000);
			repeat (300) @(posedge pclk);
		end
		setup(1'h0, 2'h0, 2'h0, 1'h1);
		host.got_q.delete();
		host.send_char(CHR_XOFF);
		apb(ADDR_TXDATA, 1'h1, {23'h0, 1'h1, c});
		repeat (400) @(posedge pclk);
		check(host.got_q.size(), 0);
		host.send_char(CHR_XON);
		wait_got(2);
		check(host.got_q[0], c);
		check(host.got_q[1], CHR_CR);
		host.got_q.delete();
		for (int i = 0; i < 48; i++) host.send_char(8'h61 + 8'(i % 20));
		repeat (20) @(posedge pclk);
		check(host.got_q.size(), 0);
		host.send_char(CHR_CR);
		wait_got(1);
		check(host.got_q[0], CHR_XOFF);
		for (int i = 0; i < 17; i++) apb(ADDR_RXDATA, 1'h0, 32'h0000_0000);
		repeat (250) @(posedge pclk);
		check(host.got_q.size(), 1);
		apb(ADDR_RXDATA, 1'h0, 32'h0000_0000);
		wait_got(2);
		check(host.got_q[1], CHR_XON);
		check(host.perr + host.ferr, 0);
		print_verdict();
	end
endmodule
`default_nettype wire

// ---- design/srp_pkg.sv ----
// Constants, types and helper functions of the serial remote port.
// Assumes one system clock; the clock rate is handed in by the top level.
// Summary of operation
// R01: Link characters default to 8 data bits, 1 stop bit, no parity.
// R02: Received codes 3 or 18 abort work and discard pending output.
// R03: Nine bit rates from 57600 down to 300 baud are selectable.
// R04: Reset selects 9600 baud.
// R05: Host and port must run the same bit rate.
// R06: Data width 7 or 8 bits, parity even, odd or none, both directions.
// R07: No parity is accepted only with 8 data bits.
// R08: Each outgoing message ends with CR, CR LF, LF or LF CR.
// R09: No hardware handshake gates transmit or receive.
// R10: XON/XOFF only when flow setting selects it.
// R11: Send XOFF when receive queue exceeds three quarters full.
// R12: After XOFF, send XON when receive queue falls below half full.
// R13: Host sends nothing after our XOFF until our XON.
// R14: Host XOFF stops our transmitter until host XON; our own XON/XOFF codes are still sent.
// R15: Characters accumulate; a command is released only after CR.
// R16: Without flow control, characters arriving to a full queue are lost.
// R17: Only TXD, RXD and ground used; RTS and CTS looped externally.
// R18: Defaults: 9600 baud, 8 bits, no parity, CR terminator, no flow.
// R19: XON 0x11, XOFF 0x13; low start bit, LSB first, idle high.
// R20: Framing or parity errored characters are dropped and flagged.
package srp_pkg;

	localparam int unsigned CLK_HZ_DEF = 100_000_000;
	localparam int unsigned BITCNT_W = 20;
	localparam int unsigned BAUD_57600 = 57600;
	localparam int unsigned BAUD_38400 = 38400;
	localparam int unsigned BAUD_19200 = 19200;
	localparam int unsigned BAUD_9600 = 9600;
	localparam int unsigned BAUD_4800 = 4800;
	localparam int unsigned BAUD_2400 = 2400;
	localparam int unsigned BAUD_1200 = 1200;
	localparam int unsigned BAUD_600 = 600;
	localparam int unsigned BAUD_300 = 300;
	localparam logic [3:0] BAUD_SEL_9600 = 4'h3;
	localparam logic [3:0] BAUD_SEL_MAX = 4'h8;

	localparam logic [7:0] CHR_CR = 8'h0D;
	localparam logic [7:0] CHR_LF = 8'h0A;
	localparam logic [7:0] CHR_XON = 8'h11;
	localparam logic [7:0] CHR_XOFF = 8'h13;
	localparam logic [7:0] CHR_BREAK_C = 8'h03;
	localparam logic [7:0] CHR_BREAK_X = 8'h12;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TXDATA = 8'h08;
	localparam logic [7:0] ADDR_RXDATA = 8'h0C;

	localparam int unsigned RXQ_AW = 6;
	localparam int unsigned RXQ_DEPTH = 64;
	localparam logic [RXQ_AW:0] RXQ_XOFF_LVL = 7'd48;
	localparam logic [RXQ_AW:0] RXQ_XON_LVL = 7'd32;
	localparam int unsigned TXQ_AW = 4;
	localparam int unsigned TXQ_DEPTH = 16;

	localparam int unsigned ST_TXFILL_LSB = 8;
	localparam int unsigned ST_XOFF_SENT = 13;
	localparam int unsigned ST_HOST_XOFF = 14;
	localparam int unsigned ST_FRAME_ERR = 15;
	localparam int unsigned ST_PARITY_ERR = 16;
	localparam int unsigned ST_OVERRUN = 17;
	localparam int unsigned ST_ABORT = 18;
	localparam int unsigned ST_CMDCNT_LSB = 24;
	localparam int unsigned TXD_EOM_BIT = 8;
	localparam int unsigned RXD_VALID_BIT = 8;

	typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2} srp_parity_type;
	typedef enum logic [1:0] {TERM_CR = 2'h0, TERM_CRLF = 2'h1, TERM_LF = 2'h2,
		TERM_LFCR = 2'h3} srp_term_type;

	typedef struct packed {
		logic flow_xon;
		srp_term_type term;
		srp_parity_type parity;
		logic data7;
		logic [3:0] baud_sel;
	} srp_cfg_type;

	// R18 factory defaults
	localparam srp_cfg_type CFG_RESET = '{flow_xon: 1'b0, term: TERM_CR, parity: PAR_NONE,
		data7: 1'b0, baud_sel: BAUD_SEL_9600};

	// R03 nine rates
	function automatic logic [BITCNT_W-1:0] srp_bit_cycles(int unsigned clk_hz, logic [3:0] sel);
		int unsigned baud;
		case (sel)
			4'h0: baud = BAUD_57600;
			4'h1: baud = BAUD_38400;
			4'h2: baud = BAUD_19200;
			4'h3: baud = BAUD_9600;
			4'h4: baud = BAUD_4800;
			4'h5: baud = BAUD_2400;
			4'h6: baud = BAUD_1200;
			4'h7: baud = BAUD_600;
			default: baud = BAUD_300;
		endcase
		return BITCNT_W'(clk_hz / baud);
	endfunction

	// R06 parity bit over 7 or 8 data bits
	function automatic logic srp_parity_bit(logic [7:0] d, logic data7, srp_parity_type par);
		logic p;
		p = data7 ? ^d[6:0] : ^d;
		return (par == PAR_ODD) ? ~p : p;
	endfunction

	function automatic logic [3:0] srp_nbits(logic data7, srp_parity_type par);
		return (data7 ? 4'h7 : 4'h8) + ((par != PAR_NONE) ? 4'h1 : 4'h0);
	endfunction

endpackage

// ---- design/srp_serial_port.sv ----
// Top of the serial remote port: APB registers, queues, flow control.
// Assumes an APB master on pclk; rxd comes from a pin, txd drives one.
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module srp_serial_port import srp_pkg::*; #(
	parameter int unsigned CLK_HZ = CLK_HZ_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	output logic txd,
	output logic cmd_ready,
	output logic abort_pulse
);
	srp_cfg_type cfg_q;
	srp_cfg_type cfg_wr;
	logic [BITCNT_W-1:0] bit_cycles;
	logic setup, access, wr_acc, rd_acc;
	logic cfg_bad, txq_full, rd_err, wr_err;

	// Receive side
	logic rx_valid, frame_err, parity_err;
	logic [7:0] rx_data;
	logic [7:0] rxq_mem [RXQ_DEPTH];
	logic [RXQ_AW:0] rxq_wp_q, rxq_rp_q, rxq_cmd_end_q;
	logic [RXQ_AW:0] rxq_fill;
	logic [RXQ_AW:0] cmd_cnt_q;
	logic rx_is_break, rx_is_flow, rx_push, rx_pop, rx_drop;

	// Transmit side
	logic [8:0] txq_mem [TXQ_DEPTH];
	logic [TXQ_AW:0] txq_wp_q, txq_rp_q;
	logic [TXQ_AW:0] txq_fill;
	logic [8:0] txq_head;
	logic tx_valid, tx_ready, tx_fire;
	logic [7:0] tx_char;
	logic [1:0] term_step_q;
	logic send_xoff_q, send_xon_q, xoff_sent_q, host_xoff_q;
	logic sel_flow, sel_term, sel_queue;
	logic tx_push, tx_pop;

	// Sticky flags
	logic frame_flag_q, parity_flag_q, overrun_flag_q, abort_flag_q;
	logic [31:0] status;
	logic [31:0] rd_mux;

	// R05 one divider paces both directions
	assign bit_cycles = srp_bit_cycles(CLK_HZ, cfg_q.baud_sel);

	srp_uart_rx u_rx (
		.pclk(pclk),
		.presetn(presetn),
		.rxd(rxd),
		.bit_cycles(bit_cycles),
		.data7(cfg_q.data7),
		.parity(cfg_q.parity),
		.rx_valid(rx_valid),
		.rx_data(rx_data),
		.frame_err(frame_err),
		.parity_err(parity_err)
	);

	// R17 data travels only on txd and rxd
	srp_uart_tx u_tx (
		.pclk(pclk),
		.presetn(presetn),
		.bit_cycles(bit_cycles),
		.data7(cfg_q.data7),
		.parity(cfg_q.parity),
		.tx_valid(tx_valid),
		.tx_data(tx_char),
		.tx_ready(tx_ready),
		.txd(txd)
	);

	// APB decode; zero wait states, answers prepared in the setup cycle
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr_acc = access && pwrite && !pslverr;
	assign rd_acc = access && !pwrite && !pslverr;
	assign pready = 1'b1;
	assign cfg_wr = srp_cfg_type'(pwdata[$bits(srp_cfg_type)-1:0]);

	// R07 seven bits without parity refused; R03 unknown rate refused
	assign cfg_bad = (cfg_wr.data7 && cfg_wr.parity == PAR_NONE)
		|| (cfg_wr.baud_sel > BAUD_SEL_MAX) || (cfg_wr.parity == 2'h3);
	assign txq_full = txq_fill == (TXQ_AW+1)'(TXQ_DEPTH);

	always_comb begin
		wr_err = 1'b1;
		case (paddr)
			ADDR_CTRL: wr_err = cfg_bad;
			ADDR_STATUS: wr_err = 1'b0;
			ADDR_TXDATA: wr_err = txq_full;
			default: wr_err = 1'b1;
		endcase
	end

	assign rd_err = !(paddr == ADDR_CTRL || paddr == ADDR_STATUS
		|| paddr == ADDR_TXDATA || paddr == ADDR_RXDATA);

	assign status = {1'b0, cmd_cnt_q, 5'h0_0, abort_flag_q, overrun_flag_q, parity_flag_q,
		frame_flag_q, host_xoff_q, xoff_sent_q, txq_fill, 1'b0, rxq_fill};

	always_comb begin
		rd_mux = '0;
		case (paddr)
			ADDR_CTRL: rd_mux = 32'(cfg_q);
			ADDR_STATUS: rd_mux = status;
			ADDR_RXDATA: begin
				if (cmd_cnt_q != '0) begin
					rd_mux = {23'h00_0000, 1'b1, rxq_mem[rxq_rp_q[RXQ_AW-1:0]]};
				end
			end
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? '0 : rd_mux;
			pslverr <= pwrite ? wr_err : rd_err;
		end
	end

	// R04 R18 defaults after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= CFG_RESET;
		end else if (wr_acc && paddr == ADDR_CTRL) begin
			cfg_q <= cfg_wr;
		end
	end

	// Receive path classification
	// R02 break codes never enter the queue
	assign rx_is_break = rx_valid && (rx_data == CHR_BREAK_C || rx_data == CHR_BREAK_X);
	// R10 flow codes only special when enabled
	assign rx_is_flow = rx_valid && cfg_q.flow_xon
		&& (rx_data == CHR_XON || rx_data == CHR_XOFF);
	assign rxq_fill = rxq_wp_q - rxq_rp_q;
	// R16 full queue loses the character
	assign rx_drop = rx_valid && !rx_is_break && !rx_is_flow
		&& rxq_fill == (RXQ_AW+1)'(RXQ_DEPTH);
	assign rx_push = rx_valid && !rx_is_break && !rx_is_flow && !rx_drop;
	// R15 reads release only completed commands
	assign rx_pop = rd_acc && paddr == ADDR_RXDATA && cmd_cnt_q != '0;

	always_ff @(posedge pclk) begin
		if (rx_push) begin
			rxq_mem[rxq_wp_q[RXQ_AW-1:0]] <= rx_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxq_wp_q <= '0;
			rxq_cmd_end_q <= '0;
		end else if (rx_is_break) begin
			// R02 half-typed command is abandoned
			rxq_wp_q <= rxq_cmd_end_q;
		end else if (rx_push) begin
			rxq_wp_q <= rxq_wp_q + 1'b1;
			if (rx_data == CHR_CR) begin
				rxq_cmd_end_q <= rxq_wp_q + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxq_rp_q <= '0;
		end else if (rx_pop) begin
			rxq_rp_q <= rxq_rp_q + 1'b1;
		end
	end

	// R15 one count per completed command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_cnt_q <= '0;
			cmd_ready <= 1'b0;
		end else begin
			cmd_cnt_q <= cmd_cnt_q + ((rx_push && rx_data == CHR_CR) ? 1'b1 : 1'b0)
				- ((rx_pop && rxq_mem[rxq_rp_q[RXQ_AW-1:0]] == CHR_CR) ? 1'b1 : 1'b0);
			cmd_ready <= (cmd_cnt_q != '0) || (rx_push && rx_data == CHR_CR);
		end
	end

	// Flow control toward the host
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			send_xoff_q <= 1'b0;
			send_xon_q <= 1'b0;
			xoff_sent_q <= 1'b0;
		end else if (!cfg_q.flow_xon) begin
			// R10 flow off, nothing pending
			send_xoff_q <= 1'b0;
			send_xon_q <= 1'b0;
			xoff_sent_q <= 1'b0;
		end else begin
			// R11 above three quarters
			if (!xoff_sent_q && !send_xoff_q && rxq_fill > RXQ_XOFF_LVL) begin
				send_xoff_q <= 1'b1;
			end
			// R12 below half after XOFF
			if (xoff_sent_q && !send_xon_q && rxq_fill < RXQ_XON_LVL) begin
				send_xon_q <= 1'b1;
			end
			if (tx_fire && sel_flow) begin
				if (send_xoff_q) begin
					send_xoff_q <= 1'b0;
					xoff_sent_q <= 1'b1;
				end else begin
					send_xon_q <= 1'b0;
					xoff_sent_q <= 1'b0;
				end
			end
		end
	end

	// Flow control from the host
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_xoff_q <= 1'b0;
		end else if (!cfg_q.flow_xon) begin
			host_xoff_q <= 1'b0;
		end else if (rx_is_flow) begin
			// R14 XOFF pauses, XON resumes
			host_xoff_q <= (rx_data == CHR_XOFF);
		end
	end

	// Transmit queue; bit 8 marks the last character of a message
	assign txq_fill = txq_wp_q - txq_rp_q;
	assign txq_head = txq_mem[txq_rp_q[TXQ_AW-1:0]];
	assign tx_push = wr_acc && paddr == ADDR_TXDATA;

	always_ff @(posedge pclk) begin
		if (tx_push) begin
			txq_mem[txq_wp_q[TXQ_AW-1:0]] <= pwdata[8:0];
		end
	end

	// Transmit source choice: flow codes first, then terminator, then data
	// R09 no modem line enters this decision
	assign sel_flow = send_xoff_q || send_xon_q;
	// R14 host pause holds message output only
	assign sel_term = !sel_flow && !host_xoff_q && term_step_q != 2'h0;
	assign sel_queue = !sel_flow && !host_xoff_q && term_step_q == 2'h0 && txq_fill != '0;
	assign tx_valid = sel_flow || sel_term || sel_queue;
	assign tx_fire = tx_valid && tx_ready;
	assign tx_pop = tx_fire && sel_queue;

	always_comb begin
		tx_char = txq_head[7:0];
		if (sel_flow) begin
			// R19 flow code values
			tx_char = send_xoff_q ? CHR_XOFF : CHR_XON;
		end else if (sel_term) begin
			// R08 terminator order
			if (term_step_q == 2'h1) begin
				tx_char = (cfg_q.term == TERM_CR || cfg_q.term == TERM_CRLF) ? CHR_CR : CHR_LF;
			end else begin
				tx_char = (cfg_q.term == TERM_CRLF) ? CHR_LF : CHR_CR;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txq_wp_q <= '0;
			txq_rp_q <= '0;
		end else if (rx_is_break) begin
			// R02 pending output discarded
			txq_wp_q <= '0;
			txq_rp_q <= '0;
		end else begin
			if (tx_push) begin
				txq_wp_q <= txq_wp_q + 1'b1;
			end
			if (tx_pop) begin
				txq_rp_q <= txq_rp_q + 1'b1;
			end
		end
	end

	// R08 terminator follows end of message
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			term_step_q <= 2'h0;
		end else if (rx_is_break) begin
			term_step_q <= 2'h0;
		end else if (tx_pop && txq_head[TXD_EOM_BIT]) begin
			term_step_q <= 2'h1;
		end else if (tx_fire && sel_term) begin
			if (term_step_q == 2'h1 && (cfg_q.term == TERM_CRLF || cfg_q.term == TERM_LFCR)) begin
				term_step_q <= 2'h2;
			end else begin
				term_step_q <= 2'h0;
			end
		end
	end

	// Sticky flags; a new event wins over a write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_flag_q <= 1'b0;
			parity_flag_q <= 1'b0;
			overrun_flag_q <= 1'b0;
			abort_flag_q <= 1'b0;
		end else begin
			if (wr_acc && paddr == ADDR_STATUS) begin
				frame_flag_q <= frame_flag_q && !pwdata[ST_FRAME_ERR];
				parity_flag_q <= parity_flag_q && !pwdata[ST_PARITY_ERR];
				overrun_flag_q <= overrun_flag_q && !pwdata[ST_OVERRUN];
				abort_flag_q <= abort_flag_q && !pwdata[ST_ABORT];
			end
			// R20 errors flagged
			if (frame_err) begin
				frame_flag_q <= 1'b1;
			end
			if (parity_err) begin
				parity_flag_q <= 1'b1;
			end
			// R16 loss is visible to software
			if (rx_drop) begin
				overrun_flag_q <= 1'b1;
			end
			if (rx_is_break) begin
				abort_flag_q <= 1'b1;
			end
		end
	end

	// R02 abort request to the instrument core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abort_pulse <= 1'b0;
		end else begin
			abort_pulse <= rx_is_break;
		end
	end
endmodule
`default_nettype wire

// ---- design/srp_uart_rx.sv ----
// Serial receiver: start, 7 or 8 data bits, optional parity, one stop.
// Assumes rxd is asynchronous to pclk; it is synchronised here.
`timescale 1ns/1ns
`default_nettype none
module srp_uart_rx import srp_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic rxd,
	input wire logic [BITCNT_W-1:0] bit_cycles,
	input wire logic data7,
	input wire srp_parity_type parity,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic frame_err,
	output logic parity_err
);
	typedef enum logic [3:0] {RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_BITS = 4'b0100,
		RX_STOP = 4'b1000} srp_rx_state_type;
	srp_rx_state_type state_q;
	logic rxd_meta_q, rxd_sync_q;
	logic [BITCNT_W-1:0] cnt_q;
	logic [3:0] idx_q;
	logic [8:0] shift_q;
	logic [7:0] word;
	logic par_rx;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxd_meta_q <= 1'b1;
			rxd_sync_q <= 1'b1;
		end else begin
			rxd_meta_q <= rxd;
			rxd_sync_q <= rxd_meta_q;
		end
	end

	assign word = data7 ? {1'b0, shift_q[6:0]} : shift_q[7:0];
	assign par_rx = data7 ? shift_q[7] : shift_q[8];

	// R19 start low, LSB first, sampled mid bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= RX_IDLE;
			cnt_q <= '0;
			idx_q <= '0;
			shift_q <= '0;
			rx_valid <= 1'b0;
			rx_data <= '0;
			frame_err <= 1'b0;
			parity_err <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			frame_err <= 1'b0;
			parity_err <= 1'b0;
			case (state_q)
				RX_IDLE: begin
					if (!rxd_sync_q) begin
						state_q <= RX_START;
						cnt_q <= bit_cycles >> 1;
					end
				end
				RX_START: begin
					if (cnt_q != '0) begin
						cnt_q <= cnt_q - 1'b1;
					end else if (!rxd_sync_q) begin
						state_q <= RX_BITS;
						cnt_q <= bit_cycles - 1'b1;
						idx_q <= '0;
					end else begin
						state_q <= RX_IDLE;
					end
				end
				RX_BITS: begin
					if (cnt_q != '0) begin
						cnt_q <= cnt_q - 1'b1;
					end else begin
						shift_q[idx_q] <= rxd_sync_q;
						cnt_q <= bit_cycles - 1'b1;
						idx_q <= idx_q + 1'b1;
						if (idx_q == srp_nbits(data7, parity) - 4'h1) begin
							state_q <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (cnt_q != '0) begin
						cnt_q <= cnt_q - 1'b1;
					end else begin
						state_q <= RX_IDLE;
						rx_data <= word;
						// R20 errored characters flagged, not delivered
						if (!rxd_sync_q) begin
							frame_err <= 1'b1;
						end else if (parity != PAR_NONE
							&& par_rx != srp_parity_bit(word, data7, parity)) begin
							parity_err <= 1'b1;
						end else begin
							rx_valid <= 1'b1;
						end
					end
				end
				default: state_q <= RX_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- design/srp_uart_tx.sv ----
// Serial transmitter: one character per valid/ready handshake.
// Assumes configuration inputs stay steady while a character is sent.
`timescale 1ns/1ns
`default_nettype none
module srp_uart_tx import srp_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [BITCNT_W-1:0] bit_cycles,
	input wire logic data7,
	input wire srp_parity_type parity,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic txd
);
	logic busy_q;
	logic [10:0] frame_q;
	logic [3:0] left_q;
	logic [BITCNT_W-1:0] cnt_q;
	logic [8:0] body;

	assign tx_ready = !busy_q;
	assign body = data7 ? {1'b1, srp_parity_bit(tx_data, data7, parity), tx_data[6:0]}
		: {(parity == PAR_NONE) || srp_parity_bit(tx_data, data7, parity), tx_data};

	// R19 idle high, start low, LSB first; R01 one stop bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			frame_q <= '1;
			left_q <= '0;
			cnt_q <= '0;
			txd <= 1'b1;
		end else if (!busy_q) begin
			txd <= 1'b1;
			if (tx_valid) begin
				busy_q <= 1'b1;
				frame_q <= {1'b1, body, 1'b0};
				left_q <= srp_nbits(data7, parity) + 4'h2;
				cnt_q <= '0;
			end
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end else if (left_q == '0) begin
			busy_q <= 1'b0;
			txd <= 1'b1;
		end else begin
			txd <= frame_q[0];
			frame_q <= {1'b1, frame_q[10:1]};
			left_q <= left_q - 1'b1;
			cnt_q <= bit_cycles - 1'b1;
		end
	end
endmodule
`default_nettype wire
